/* File: verilog/drc_defs.vh */
// Constants for the decade ripple counter
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// Cycle lengths of the three-stage section
`define DRC_LEN_DECADE   4'h5
`define DRC_LEN_TWELVE   4'h6
`define DRC_LEN_BINARY   4'h8

// Forced values of the three-stage section and the divide-by-two stage
`define DRC_HI_ZERO      3'h0
`define DRC_HI_NINE      3'h4
`define DRC_HI_ONE       3'h1
`define DRC_LO_ZERO      1'h0
`define DRC_LO_NINE      1'h1

// Synchronised input vector layout
`define DRC_SYNC_W       6
`define DRC_IDX_CNT_A    0
`define DRC_IDX_CNT_B    1
`define DRC_IDX_CLR_A    2
`define DRC_IDX_CLR_B    3
`define DRC_IDX_PRE_A    4
`define DRC_IDX_PRE_B    5

// Reset values
`define DRC_SYNC_RST     6'h00

`endif

/* File: verilog/drc_counter.v */
// Divide-by-two plus three-stage counter with gated clear and preset
`timescale 1ns/1ps
`default_nettype none
`include "drc_defs.vh"

// Contract
// R01 - Four stages: one divide-by-two stage stepped by count A, three stages stepped by count B.
// R02 - The decade variant's three-stage section cycles through five states, dividing by five.
// R03 - Variant lengths six and eight are available and they ignore the preset-to-nine inputs.
// R04 - Both clear-to-zero inputs high force all four outputs low regardless of counting.
// R05 - In the decade variant both preset inputs high force the outputs to binary nine.
// R06 - For BCD counting the outside links bit 0 to count B and drives count A.
// R07 - For a symmetric divide-by-ten the outside links bit 3 to count A and drives count B.
// R08 - Preset beats clear, and counting happens on falling count edges only when neither forces.
module drc_counter #(
    parameter [3:0] SECTION_LEN = `DRC_LEN_DECADE
) (
    input  wire ref_clk_in,
    input  wire rstn_in,
    input  wire clk_en_in,
    input  wire count_a_in,
    input  wire count_b_in,
    input  wire clear_zero_a_in,
    input  wire clear_zero_b_in,
    input  wire preset_nine_a_in,
    input  wire preset_nine_b_in,
    output wire cnt_bit0_out,
    output wire cnt_bit1_out,
    output wire cnt_bit2_out,
    output wire cnt_bit3_out
);

    wire [`DRC_SYNC_W-1:0] raw_in;
    reg  [`DRC_SYNC_W-1:0] meta_reg;
    reg  [`DRC_SYNC_W-1:0] sync_reg;
    reg  [1:0]             cnt_prev_reg;
    reg                    lo_reg;
    reg                    lo_next;
    reg  [2:0]             hi_reg;
    reg  [2:0]             hi_next;
    wire                   clear_all;
    wire                   preset_all;
    wire                   fall_a;
    wire                   fall_b;
    wire                   has_preset;

    assign raw_in = {preset_nine_b_in, preset_nine_a_in,
                     clear_zero_b_in, clear_zero_a_in,
                     count_b_in, count_a_in};

    // Two flops per pin; only the second is read
    genvar gi;
    generate
        for (gi = 0; gi < `DRC_SYNC_W; gi = gi + 1) begin : g_sync
            always @(posedge ref_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else if (clk_en_in) begin
                    meta_reg[gi] <= raw_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    // Next state of the three-stage section with wrap at the variant length
    function [2:0] drc_hi_step;
        input [2:0] cur;
        input [3:0] len;
        reg   [3:0] nxt;
        begin
            nxt = {1'b0, cur} + 4'h1;
            if (nxt >= len) begin
                drc_hi_step = `DRC_HI_ZERO;
            end else begin
                drc_hi_step = nxt[2:0];
            end
        end
    endfunction

    // Only the decade variant has preset inputs
    assign has_preset = (SECTION_LEN == `DRC_LEN_DECADE); // R03
    assign clear_all  = sync_reg[`DRC_IDX_CLR_A] & sync_reg[`DRC_IDX_CLR_B]; // R04
    assign preset_all = has_preset & sync_reg[`DRC_IDX_PRE_A]
                        & sync_reg[`DRC_IDX_PRE_B]; // R05

    // Falling edges stand in for the ripple clocks of the original stages
    assign fall_a = cnt_prev_reg[`DRC_IDX_CNT_A] & ~sync_reg[`DRC_IDX_CNT_A];
    assign fall_b = cnt_prev_reg[`DRC_IDX_CNT_B] & ~sync_reg[`DRC_IDX_CNT_B];

    always @* begin
        lo_next = lo_reg;
        hi_next = hi_reg;
        if (preset_all) begin // R08
            lo_next = `DRC_LO_NINE; // R05
            hi_next = `DRC_HI_NINE; // R05
        end else if (clear_all) begin
            lo_next = `DRC_LO_ZERO; // R04
            hi_next = `DRC_HI_ZERO; // R04
        end else begin
            if (fall_a) begin // R08
                lo_next = ~lo_reg; // R01
            end
            if (fall_b) begin // R08
                hi_next = drc_hi_step(hi_reg, SECTION_LEN); // R01 R02 R03
            end
        end
    end

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_prev_reg <= 2'h0;
            lo_reg       <= `DRC_LO_ZERO;
            hi_reg       <= `DRC_HI_ZERO;
        end else if (clk_en_in) begin
            cnt_prev_reg <= sync_reg[`DRC_IDX_CNT_B:`DRC_IDX_CNT_A];
            lo_reg       <= lo_next;
            hi_reg       <= hi_next;
        end
    end

    // External chaining (bit 0 to B, or bit 3 to A) adds sync latency per stage
    assign cnt_bit0_out = lo_reg; // R06 R07
    assign cnt_bit1_out = hi_reg[0];
    assign cnt_bit2_out = hi_reg[1];
    assign cnt_bit3_out = hi_reg[2];

endmodule // drc_counter
`default_nettype wire

/* File: test/drc_counter_properties.sv */
// Port assertions for the counter
`timescale 1ns/1ps
`default_nettype none
module drc_counter_properties #(parameter [3:0] SECTION_LEN = 4'h5) (
    input wire ref_clk_in, rstn_in, clk_en_in, count_a_in, count_b_in,
    input wire clear_zero_a_in, clear_zero_b_in, preset_nine_a_in, preset_nine_b_in,
    input wire cnt_bit0_out, cnt_bit1_out, cnt_bit2_out, cnt_bit3_out);
    wire       clr = clear_zero_a_in & clear_zero_b_in;
    wire       pre = preset_nine_a_in & preset_nine_b_in & (SECTION_LEN == 4'h5);
    wire       ok  = clk_en_in & ~clr & ~pre;
    wire [3:0] s   = {1'b0, cnt_bit3_out, cnt_bit2_out, cnt_bit1_out};
    wire [3:0] q   = {cnt_bit3_out, cnt_bit2_out, cnt_bit1_out, cnt_bit0_out};
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence fall(x); $fell(x) && ok ##1 ok [*2]; endsequence
    a_clear_zero: assert property ((clk_en_in & clr & ~pre) [*3] |=> q == 4'h0)
        else $error("clear missed");
    a_preset_nine: assert property ((clk_en_in & pre) [*3] |=> q == 4'h9)
        else $error("preset missed");
    a_section_range: assert property (s < SECTION_LEN) else $error("section range");
    a_low_toggle: assert property (fall(count_a_in) |=> cnt_bit0_out != $past(cnt_bit0_out))
        else $error("bit0 step");
    a_section_step: assert property (fall(count_b_in) |=>
        s == (($past(s) == SECTION_LEN - 4'h1) ? 4'h0 : $past(s) + 4'h1)) else $error("step");
    a_quiet_hold: assert property ((ok & $stable(count_a_in) & $stable(count_b_in)) [*4]
        |=> $stable(q)) else $error("moved");
endmodule // drc_counter_properties
bind drc_counter drc_counter_properties #(.SECTION_LEN(SECTION_LEN)) u_chk (.*);
`default_nettype wire

/* File: test/drc_upstream.sv */
// Upstream pulse source with both chaining modes
`timescale 1ns/1ps
`default_nettype none
module drc_upstream (
    input  wire logic ref_clk_in, biq_in, bit0_in, bit3_in,
    output logic      count_a_out, count_b_out, pulse_out);
    logic [2:0] div_reg = 3'h0;
    // Six cycles each level, well above the two-cycle minimum
    always @(posedge ref_clk_in) begin
        div_reg <= (div_reg == 3'h5) ? 3'h0 : div_reg + 3'h1;
        if (div_reg == 3'h5) pulse_out <= ~pulse_out;
    end
    initial pulse_out = 1'b1;
    assign count_a_out = biq_in ? bit3_in : pulse_out;
    assign count_b_out = biq_in ? pulse_out : bit0_in;
endmodule // drc_upstream
`default_nettype wire

/* File: test/drc_counter_test.sv */
// Self-checking bench for the counter
`timescale 1ns/1ps
`default_nettype none
module drc_counter_test;
    logic       ref_clk_in = 1'b0, rstn_in = 1'b0, biq = 1'b0, ca, cb, pl, b0, b1, b2, b3;
    logic [3:0] frc = 4'h0;
    logic       en = 1'b1;
    int         num_errors = 0, samples_checked = 0, cycles = 0;
    always #25 ref_clk_in = ~ref_clk_in;
    drc_upstream u_src (.ref_clk_in(ref_clk_in), .biq_in(biq), .bit0_in(b0), .bit3_in(b3),
        .count_a_out(ca), .count_b_out(cb), .pulse_out(pl));
    drc_counter u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .clk_en_in(en),
        .count_a_in(ca), .count_b_in(cb), .clear_zero_a_in(frc[0]), .clear_zero_b_in(frc[1]),
        .preset_nine_a_in(frc[2]), .preset_nine_b_in(frc[3]), .cnt_bit0_out(b0),
        .cnt_bit1_out(b1), .cnt_bit2_out(b2), .cnt_bit3_out(b3));
    task automatic chk(input logic [3:0] e);
        samples_checked++;
        if ({b3, b2, b1, b0} !== e) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, {b3, b2, b1, b0}, e);
        end
    endtask
    task automatic set_force(input logic [3:0] f, input logic [3:0] e);
        frc = f;
        repeat (5) @(posedge ref_clk_in);
        #1 chk(e);
    endtask
    task automatic t_forces;
        set_force(4'h3, 4'h0);
        set_force(4'hF, 4'h9);
        set_force(4'h7, 4'h0);
        set_force(4'hE, 4'h9);
    endtask
    // Clear held over the mode switch so its glitch cannot count
    task automatic t_count(input logic m);
        frc = 4'h3;
        biq = m;
        @(posedge pl);
        #1 frc = 4'h0;
        for (int n = 1; n <= 20; n++) begin
            @(negedge pl);
            repeat (10) @(posedge ref_clk_in);
            #1 chk(m ? {3'(n % 5), 1'(n % 10 >= 5)} : 4'(n % 10));
        end
    endtask
    // Pulses keep running, so a live counter would have moved by now
    task automatic t_freeze;
        en = 1'b0;
        repeat (24) @(posedge ref_clk_in);
        #1 chk(4'h0);
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles > 2000) begin
            num_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk_in);
        #1 chk(4'h0);
        rstn_in = 1'b1;
        t_forces;
        t_count(1'b0);
        t_count(1'b1);
        t_freeze;
        report_and_stop;
    end
endmodule // drc_counter_test
`default_nettype wire
